// File: hw/ocs_params.svh
// Constants of the oscillator clock select block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design module.
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH
// Byte addresses of the registers on the AXI4-Lite slave.
`define OCS_ADDR_REF_CTRL   8'h00
`define OCS_ADDR_OSC_CTRL   8'h04
`define OCS_ADDR_IRQ_STAT   8'h08
`define OCS_ADDR_IRQ_CLR    8'h0C
`define OCS_ADDR_IRQ_EN     8'h10
// Field positions.
`define OCS_REF_OE_BIT      6
`define OCS_SEL_LSB         4
`define OCS_SEL_MSB         6
`define OCS_HF_READY_BIT    3
`define OCS_LF_READY_BIT    1
`define OCS_HF_STABLE_BIT   0
// Mask of the implemented status and event bits.
`define OCS_EVT_MASK        8'h0B
// Reset values and encodings.
`define OCS_SEL_RESET       3'h6
`define OCS_SEL_LF          3'h0
`define OCS_SEL_FULL        3'h7
`define OCS_DIV_ALL         6'h3F
`define OCS_RESP_OKAY       2'h0
`define OCS_RESP_SLVERR     2'h2
`endif

// File: hw/ocs_pkg.sv
// Types shared by the oscillator clock select block.
// Assumes the constants header sits beside it.
`include "ocs_params.svh"
package ocs_pkg;
	typedef logic [2:0] ocs_freq_sel_t;
	typedef logic [7:0] ocs_reg8_t;
	typedef logic [1:0] ocs_resp_t;
endpackage : ocs_pkg

// File: hw/ocs_clock_select.sv
// Oscillator clock select: source choice, divider, ready flags, reference out.
// Assumes oscillator ticks and pins are synchronous pulses/levels on SYS_CLK,
// except the three oscillator status levels, which are synchronised here.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "ocs_params.svh"

// Notes on behaviour
// R01 - Source bit zero runs the system clock from the internal oscillators.
// R02 - Source bit one takes the system clock from the external clock pin.
// R03 - In internal mode the external clock pin is released as general I/O.
// R04 - High choices divide the 16 MHz oscillator; 31 kHz gives the slowest.
// R05 - Select 111..001 give 16M down to 250k; 000 gives 31 kHz.
// R06 - Any reset loads the select field with 110, that is 8 MHz.
// R07 - Changing between high settings acts at once, with no start-up delay.
// R08 - High ready flag follows the fast, coarse secondary clock's ready.
// R09 - High stable flag stays zero until the accurate primary clock is stable.
// R10 - Low ready flag reports readiness of the 31 kHz oscillator.
// R11 - Output enable drives Fosc/4 on the reference pin, overriding direction.
// R12 - Unimplemented control register bits read as zero.
// R13 - Oscillator status levels are synchronised before software sees them.
module ocs_clock_select (
	input  wire logic        SYS_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        CLK_SRC_CFG,
	input  wire logic        EXT_CLK_IN,
	input  wire logic        HF_OSC_TICK,
	input  wire logic        LF_OSC_TICK,
	input  wire logic        HF_SEC_READY,
	input  wire logic        HF_PRI_STABLE,
	input  wire logic        LF_READY,
	input  wire logic        PIN_DIR_IN,
	output logic             FOSC_TICK,
	output logic             EXT_PIN_GPIO_EN,
	output logic             EXT_PIN_GPIO_IN,
	output logic             REF_PIN_O,
	output logic             REF_PIN_OE_N,
	output logic             IRQ,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        WVALID,
	output logic             WREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	output logic             BVALID,
	input  wire logic        BREADY,
	output logic [1:0]       BRESP,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	input  wire logic [7:0]  ARADDR,
	output logic             RVALID,
	input  wire logic        RREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP
);

	////////////////////////////////////////////////////////////////////////
	ocs_pkg::ocs_freq_sel_t freq_sel;
	logic                   ref_oe;
	logic                   cfg_ext;
	logic [2:0]             sync1;
	logic [2:0]             sync2;
	logic [2:0]             sync3;
	logic                   hf_rdy;
	logic                   hf_stab;
	logic                   lf_rdy;
	logic                   ext_q;
	logic                   ext_rise;
	logic [5:0]             div_cnt;
	logic [5:0]             div_mask;
	logic                   next_tick;
	logic [1:0]             ref_cnt;
	ocs_pkg::ocs_reg8_t     irq_stat;
	ocs_pkg::ocs_reg8_t     irq_en;
	ocs_pkg::ocs_reg8_t     evt;
	ocs_pkg::ocs_reg8_t     clr;
	ocs_pkg::ocs_reg8_t     osc_rd;
	logic [7:0]             aw_addr;
	logic [7:0]             w_data;
	logic                   w_lane0;
	logic                   aw_held;
	logic                   w_held;
	logic                   do_write;

	// The source bit is sampled by the clock on every cycle after reset release.
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cfg_ext <= 1'b0;
		end else begin
			cfg_ext <= CLK_SRC_CFG;
		end
	end

	// Two flip-flops per status level; the third stage only feeds edge events.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
				end else begin
					sync1[gi] <= (gi == 0) ? HF_PRI_STABLE :
						(gi == 1) ? LF_READY : HF_SEC_READY; // see R13
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
				end
			end
		end
	endgenerate
	assign hf_stab = sync2[0]; // see R09
	assign lf_rdy  = sync2[1]; // see R10
	assign hf_rdy  = sync2[2]; // see R08

	////////////////////////////////////////////////////////////////////////
	// The divider runs freely, so a new select acts on the next tick.
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			div_cnt <= 6'h00;
			ext_q   <= 1'b0;
		end else begin
			ext_q <= EXT_CLK_IN;
			if (HF_OSC_TICK) begin
				div_cnt <= div_cnt + 6'h01; // see R04
			end
		end
	end

	assign ext_rise = EXT_CLK_IN & ~ext_q;
	assign div_mask = `OCS_DIV_ALL >> (freq_sel - 3'h1); // see R05

	// Pick the system clock event: external edge, 31 kHz tick or divided tick.
	always_comb begin
		if (cfg_ext) begin
			next_tick = ext_rise; // see R02
		end else if (freq_sel == `OCS_SEL_LF) begin
			next_tick = LF_OSC_TICK; // see R04
		end else begin
			next_tick = HF_OSC_TICK && ((div_cnt & div_mask) == div_mask); // see R01 R07
		end
	end

	// Reference output toggles every second system tick, giving Fosc/4.
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			FOSC_TICK       <= 1'b0;
			ref_cnt         <= 2'h0;
			REF_PIN_O       <= 1'b0;
			EXT_PIN_GPIO_EN <= 1'b0;
			EXT_PIN_GPIO_IN <= 1'b0;
		end else begin
			FOSC_TICK       <= next_tick;
			EXT_PIN_GPIO_EN <= ~cfg_ext; // see R03
			EXT_PIN_GPIO_IN <= cfg_ext ? 1'b0 : EXT_CLK_IN;
			if (!ref_oe) begin
				ref_cnt <= 2'h0;
			end else if (next_tick) begin
				ref_cnt <= ref_cnt + 2'h1; // see R11
			end
			REF_PIN_O <= ref_oe & ref_cnt[1];
		end
	end

	// Enable overrides the direction control; otherwise direction rules.
	assign REF_PIN_OE_N = ref_oe ? 1'b0 : PIN_DIR_IN; // see R11

	////////////////////////////////////////////////////////////////////////
	// Write address and data are held separately and taken in either order.
	assign AWREADY  = ~aw_held & ~BVALID;
	assign WREADY   = ~w_held & ~BVALID;
	assign do_write = aw_held & w_held & ~BVALID;
	assign ARREADY  = ~RVALID;

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 8'h00;
			w_lane0 <= 1'b0;
			BVALID  <= 1'b0;
			BRESP   <= `OCS_RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_held  <= 1'b1;
				w_data  <= WDATA[7:0];
				w_lane0 <= WSTRB[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				BVALID  <= 1'b1;
				BRESP   <= (aw_addr > `OCS_ADDR_IRQ_EN || aw_addr[1:0] != 2'h0) ?
					`OCS_RESP_SLVERR : `OCS_RESP_OKAY;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// Control fields; only byte lane zero carries implemented bits.
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			freq_sel <= `OCS_SEL_RESET; // see R06
			ref_oe   <= 1'b0;
			irq_en   <= 8'h00;
		end else if (do_write && w_lane0) begin
			case (aw_addr)
				`OCS_ADDR_REF_CTRL: ref_oe <= w_data[`OCS_REF_OE_BIT];
				`OCS_ADDR_OSC_CTRL: freq_sel <= w_data[`OCS_SEL_MSB:`OCS_SEL_LSB]; // see R07
				`OCS_ADDR_IRQ_EN:   irq_en <= w_data & `OCS_EVT_MASK;
				default:            ref_oe <= ref_oe;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Rising status flags are events; a new event wins over a clear.
	assign evt = {4'h0, sync2[2] & ~sync3[2], 1'b0, sync2[1] & ~sync3[1],
		sync2[0] & ~sync3[0]};
	assign clr = (do_write && w_lane0 && aw_addr == `OCS_ADDR_IRQ_CLR) ? w_data : 8'h00;

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_stat <= 8'h00;
		end else begin
			irq_stat <= ((irq_stat & ~clr) | evt) & `OCS_EVT_MASK;
		end
	end

	assign IRQ = |(irq_stat & irq_en);

	// Reserved positions are held at zero in the read image.
	assign osc_rd = {1'b0, freq_sel, hf_rdy, 1'b0, lf_rdy, hf_stab}; // see R12

	// One read at a time; data appear one cycle after the address is taken.
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RVALID <= 1'b0;
			RDATA  <= 32'h0000_0000;
			RRESP  <= `OCS_RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RRESP  <= `OCS_RESP_OKAY;
			case (ARADDR)
				`OCS_ADDR_REF_CTRL: RDATA <= {25'h0, ref_oe, 6'h00}; // see R12
				`OCS_ADDR_OSC_CTRL: RDATA <= {24'h0, osc_rd};
				`OCS_ADDR_IRQ_STAT: RDATA <= {24'h0, irq_stat};
				`OCS_ADDR_IRQ_EN:   RDATA <= {24'h0, irq_en};
				`OCS_ADDR_IRQ_CLR:  RDATA <= 32'h0000_0000;
				default: begin
					RDATA <= 32'h0000_0000;
					RRESP <= `OCS_RESP_SLVERR;
				end
			endcase
		end else if (RREADY) begin
			RVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks next to the logic they guard.
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	AST_INT_FULL: assert property (!cfg_ext && freq_sel == 3'h7 && HF_OSC_TICK // see R01
		|=> FOSC_TICK) else $error("Full rate tick missed.");
	AST_EXT_EDGE: assert property (cfg_ext && EXT_CLK_IN && !ext_q // see R02
		|=> FOSC_TICK) else $error("External edge did not clock.");
	// The edge that leaves reset still loads reset values, so it starts no attempt.
	AST_GPIO_REL: assert property (!SYS_RST && !cfg_ext |=> EXT_PIN_GPIO_EN) // see R03
		else $error("Pin not released in internal mode.");
	AST_HF_ONLY: assert property (!cfg_ext && freq_sel != 3'h0 && !HF_OSC_TICK // see R04
		|=> !FOSC_TICK) else $error("Tick without oscillator tick.");
	AST_LF_SEL: assert property (!cfg_ext && freq_sel == 3'h0 && LF_OSC_TICK // see R05
		|=> FOSC_TICK) else $error("Slow oscillator not selected.");
	AST_RST_SEL: assert property ($past(SYS_RST) |-> freq_sel == 3'h6) // see R06
		else $error("Select not 110 after reset.");
	AST_DIV_250K: assert property (!cfg_ext && freq_sel == 3'h1 && HF_OSC_TICK // see R07
		&& div_cnt != 6'h3F |=> !FOSC_TICK) else $error("Divide by 64 wrong.");
	AST_HF_READY: assert property (!SYS_RST && HF_SEC_READY |-> ##2 hf_rdy) // see R08
		else $error("Ready flag late.");
	AST_HF_STAB: assert property (!HF_PRI_STABLE |-> ##2 !hf_stab) // see R09
		else $error("Stable flag set early.");
	AST_LF_READY: assert property (!SYS_RST && LF_READY ##1 !LF_READY // see R10
		|-> ##1 lf_rdy ##1 !lf_rdy) else $error("Slow ready flag wrong.");
	AST_REF_OE: assert property (ref_oe |-> !REF_PIN_OE_N) // see R11
		else $error("Reference pin not driven.");
	AST_RSVD: assert property (RVALID |-> RDATA[31:7] == 25'h0 && RDATA[2] == 1'b0) // see R12
		else $error("Reserved bit set.");
	AST_SYNC: assert property ($rose(HF_PRI_STABLE) |=> !hf_stab) // see R13
		else $error("Status not synchronised.");

	COV_WRITE: cover property (do_write ##1 BVALID && BREADY);
	COV_READ: cover property (ARVALID && ARREADY ##1 RVALID);
	COV_IRQ: cover property ($rose(IRQ));
	COV_REF: cover property (ref_oe && $rose(REF_PIN_O));

endmodule : ocs_clock_select

// File: test/ocs_ext_src.sv
// External clock source model driving the clock input pin of the block.
// Assumes the bench's system clock; the pin is a synchronous level.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// While enabled, the pin toggles every HALF cycles. When disabled it holds
// the idle level, so a stale clock level is never taken for a live source.
module ocs_ext_src #(
	parameter int HALF = 4
) (
	input  wire logic clk,
	input  wire logic enable,
	input  wire logic idle_level,
	output logic      pin
);
	int   cnt;
	logic phase;
	// The half-period counter restarts whenever the source is stopped.
	always_ff @(posedge clk) begin
		if (!enable) begin
			cnt   <= 0;
			phase <= 1'h0;
		end else if (cnt == HALF - 1) begin
			cnt   <= 0;
			phase <= ~phase;
		end else begin
			cnt <= cnt + 1;
		end
	end
	assign pin = enable ? phase : idle_level;
endmodule : ocs_ext_src

// File: test/oscillator_clock_select_test.sv
// Self-checking bench for the oscillator clock select block.
// Assumes the design files and the external source model are compiled first.
`timescale 1ns/100ps
`include "ocs_params.svh"
////////////////////////////////////////////////////////////////
module oscillator_clock_select_test;
	logic SYS_CLK = 1'h0, SYS_RST = 1'h1, CLK_SRC_CFG = 1'h0, HF_OSC_TICK = 1'h1, LF_OSC_TICK = 1'h0;
	logic HF_SEC_READY = 1'h0, HF_PRI_STABLE = 1'h0, LF_READY = 1'h0, PIN_DIR_IN = 1'h1;
	logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
	logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h0000_0000, RDATA, d;
	logic [3:0]  WSTRB = 4'hF;
	logic [1:0]  BRESP, RRESP, r;
	logic        EXT_CLK_IN, FOSC_TICK, EXT_PIN_GPIO_EN, EXT_PIN_GPIO_IN, REF_PIN_O, REF_PIN_OE_N;
	logic        IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID, src_en = 1'h0, idle_lvl = 1'h0;
	int          checks = 0, miscompares = 0, cycles = 0, m_sel = 6, n;
	ocs_clock_select u_dut (.*);
	ocs_ext_src u_src (.clk(SYS_CLK), .enable(src_en), .idle_level(idle_lvl), .pin(EXT_CLK_IN));
	// The clock runs at 100 MHz.
	initial begin
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	// High ticks every second cycle, low every fourth; the run is cut short if it hangs.
	always @(posedge SYS_CLK) begin
		cycles <= cycles + 1;
		HF_OSC_TICK <= cycles[0];
		LF_OSC_TICK <= (cycles % 4 == 3);
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Address and data are offered together and each is released once taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
		logic aw_t, w_t, aw_d, w_d;
		@(posedge SYS_CLK);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		aw_d = 1'h0;
		w_d = 1'h0;
		while (!(aw_d && w_d)) begin
			@(negedge SYS_CLK);
			aw_t = AWREADY;
			w_t = WREADY;
			@(posedge SYS_CLK);
			if (aw_t && !aw_d) AWVALID <= 1'h0;
			if (w_t && !w_d) WVALID <= 1'h0;
			aw_d = aw_d | aw_t;
			w_d = w_d | w_t;
		end
		aw_t = 1'h0;
		while (!aw_t) begin
			@(negedge SYS_CLK);
			aw_t = BVALID;
			rsp = BRESP;
			@(posedge SYS_CLK);
		end
		BREADY <= 1'h0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
		logic t;
		@(posedge SYS_CLK);
		ARADDR <= a;
		ARVALID <= 1'h1;
		t = 1'h0;
		while (!t) begin
			@(negedge SYS_CLK);
			t = ARREADY;
			@(posedge SYS_CLK);
		end
		ARVALID <= 1'h0;
		RREADY <= 1'h1;
		t = 1'h0;
		while (!t) begin
			@(negedge SYS_CLK);
			t = RVALID;
			v = RDATA;
			rsp = RRESP;
			@(posedge SYS_CLK);
		end
		RREADY <= 1'h0;
	endtask : axi_rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] v;
		logic [1:0]  rsp;
		axi_rd(a, v, rsp);
		chk(v, e);
		chk({30'h0, rsp}, {30'h0, er});
	endtask : rd_chk
	// Counts system clock ticks, or reference output rises, over 128 cycles.
	task automatic count(input bit use_ref, output int cnt);
		logic prev, cur;
		cnt = 0;
		@(negedge SYS_CLK);
		prev = REF_PIN_O;
		repeat (128) begin
			@(negedge SYS_CLK);
			cur = use_ref ? REF_PIN_O : FOSC_TICK;
			if (use_ref ? (cur && !prev) : cur) cnt++;
			prev = cur;
		end
	endtask : count
	// Expected ticks in 128 cycles: high ticks come every second cycle, low every fourth.
	function automatic int exp_ticks(int s);
		return (s == 0) ? 32 : (64 >> (7 - s));
	endfunction : exp_ticks
	task automatic results();
		$display("Checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results
	initial begin
		void'($urandom(32'h16ea));
		repeat (10) @(posedge SYS_CLK);
		SYS_RST <= 1'h0;
		rd_chk(`OCS_ADDR_OSC_CTRL, 32'h0000_0060, `OCS_RESP_OKAY);
		rd_chk(`OCS_ADDR_REF_CTRL, 32'h0000_0000, `OCS_RESP_OKAY);
		$display("Test reset values done");
		// Every select code, with random noise in the read-only and reserved bits.
		for (int s = 0; s < 8; s++) begin
			d = ($urandom() & 32'h0000_008F) | (s << 4);
			axi_wr(`OCS_ADDR_OSC_CTRL, d, r);
			chk({30'h0, r}, {30'h0, `OCS_RESP_OKAY});
			m_sel = s;
			count(1'b0, n);
			chk(n, exp_ticks(m_sel));
			rd_chk(`OCS_ADDR_OSC_CTRL, m_sel << 4, `OCS_RESP_OKAY);
		end
		$display("Test frequency select done");
		PIN_DIR_IN <= 1'($urandom());
		axi_wr(`OCS_ADDR_REF_CTRL, $urandom() | 32'h0000_0040, r);
		rd_chk(`OCS_ADDR_REF_CTRL, 32'h0000_0040, `OCS_RESP_OKAY);
		count(1'b1, n);
		chk(n, 16);
		chk({31'h0, REF_PIN_OE_N}, 32'h0000_0000);
		axi_wr(`OCS_ADDR_REF_CTRL, 32'h0000_0000, r);
		count(1'b1, n);
		chk(n, 0);
		chk({31'h0, REF_PIN_OE_N}, {31'h0, PIN_DIR_IN});
		$display("Test reference output done");
		@(posedge SYS_CLK);
		idle_lvl <= 1'h1;
		repeat (4) @(negedge SYS_CLK);
		chk({30'h0, EXT_PIN_GPIO_EN, EXT_PIN_GPIO_IN}, 32'h0000_0003);
		@(posedge SYS_CLK);
		CLK_SRC_CFG <= 1'h1;
		src_en <= 1'h1;
		repeat (16) @(posedge SYS_CLK);
		count(1'b0, n);
		chk(n, 16);
		chk({31'h0, EXT_PIN_GPIO_EN}, 32'h0000_0000);
		@(posedge SYS_CLK);
		CLK_SRC_CFG <= 1'h0;
		src_en <= 1'h0;
		repeat (4) @(posedge SYS_CLK);
		count(1'b0, n);
		chk(n, exp_ticks(m_sel));
		$display("Test clock source done");
		HF_SEC_READY <= 1'h1;
		repeat (6) @(posedge SYS_CLK);
		rd_chk(`OCS_ADDR_OSC_CTRL, 32'h0000_0078, `OCS_RESP_OKAY);
		rd_chk(`OCS_ADDR_IRQ_STAT, 32'h0000_0008, `OCS_RESP_OKAY);
		chk({31'h0, IRQ}, 32'h0000_0000);
		axi_wr(`OCS_ADDR_IRQ_EN, 32'h0000_000B, r);
		@(negedge SYS_CLK);
		chk({31'h0, IRQ}, 32'h0000_0001);
		axi_wr(`OCS_ADDR_IRQ_CLR, 32'h0000_0008, r);
		@(negedge SYS_CLK);
		chk({31'h0, IRQ}, 32'h0000_0000);
		@(posedge SYS_CLK);
		HF_PRI_STABLE <= 1'h1;
		LF_READY <= 1'h1;
		repeat (6) @(posedge SYS_CLK);
		rd_chk(`OCS_ADDR_OSC_CTRL, 32'h0000_007B, `OCS_RESP_OKAY);
		chk({31'h0, IRQ}, 32'h0000_0001);
		axi_wr(`OCS_ADDR_IRQ_CLR, 32'h0000_000B, r);
		rd_chk(`OCS_ADDR_IRQ_STAT, 32'h0000_0000, `OCS_RESP_OKAY);
		rd_chk(`OCS_ADDR_IRQ_CLR, 32'h0000_0000, `OCS_RESP_OKAY);
		rd_chk(8'h20, 32'h0000_0000, `OCS_RESP_SLVERR);
		// Refused writes: a misaligned address, and a write without byte lane zero.
		axi_wr(8'h05, 32'h0000_0000, r);
		chk({30'h0, r}, {30'h0, `OCS_RESP_SLVERR});
		WSTRB <= 4'hE;
		axi_wr(`OCS_ADDR_OSC_CTRL, 32'h0000_0000, r);
		chk({30'h0, r}, {30'h0, `OCS_RESP_OKAY});
		WSTRB <= 4'hF;
		LF_READY <= 1'h0;
		repeat (4) @(posedge SYS_CLK);
		rd_chk(`OCS_ADDR_OSC_CTRL, 32'h0000_0079, `OCS_RESP_OKAY);
		$display("Test status and interrupts done");
		results();
	end
endmodule : oscillator_clock_select_test
